// ===== verilog/rsb_defs.vh
// Constants for the reset sequencer with brown-out control
`ifndef RSB_DEFS_VH
`define RSB_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define RSB_ADDR_BROWNOUT_CONTROL 4'h0
`define RSB_ADDR_RESET_STATUS     4'h4

// ----------------------------------------
// Brownout control fields and reset value
// ----------------------------------------
`define RSB_BIT_SW_ENABLE         7
`define RSB_BIT_FAST_START        6
`define RSB_BIT_READY             0
`define RSB_SW_ENABLE_RESET       1'b1
`define RSB_FAST_START_RESET      1'b0

// ----------------------------------------
// Reset status fields
// ----------------------------------------
`define RSB_BIT_BROWNOUT_FLAG_N   0
`define RSB_BIT_TIMEOUT_N         1
`define RSB_BIT_POWERDOWN_N       2
`define RSB_BIT_RUNNING           3

// ----------------------------------------
// Brownout modes
// ----------------------------------------
`define RSB_MODE_ALWAYS_ON        2'b11
`define RSB_MODE_OFF_IN_SLEEP     2'b10
`define RSB_MODE_SOFTWARE         2'b01
`define RSB_MODE_OFF              2'b00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSB_CLK_HZ                20000000
`define RSB_LF_TICK_HZ            31000
`define RSB_PWRUP_DELAY_MS        64
`define RSB_PWRUP_TICKS           ((`RSB_PWRUP_DELAY_MS * `RSB_LF_TICK_HZ) / 1000)
`define RSB_PIN_RELEASE_CYCLES    10
`define RSB_FILTER_NS             1000
`define RSB_FILTER_CYCLES         ((`RSB_FILTER_NS * (`RSB_CLK_HZ / 1000000)) / 1000)
`define RSB_PIN_FILTER_CYCLES     4

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RSB_RESP_OKAY             2'b00
`define RSB_RESP_SLVERR           2'b10

`endif

// ===== verilog/rsb_reset_sequencer.v
// Reset sequencer: power-on, brownout, pin, watchdog and programming-exit reset control
// Function
// (R1) Power-up delay holds reset after power/brownout
// (R2) Delay timer enabled when disable_n bit cleared
// (R3) Delay counts only after power-on, brownout release; here it also runs after a watchdog timeout
// (R4) Two-bit field selects brownout mode
// (R5) Always-on: startup waits; sleep protected, no wake delay
// (R6) Off-in-sleep: startup and wake wait ready
// (R7) Software mode: no startup wait; sleep ignored
// (R8) Monitor disabled: release immediate, ready don't-care
// (R9) Brownout only after dip exceeds filter time
// (R10) Software enable bit 7, acts only mode 01
// (R11) Fast-start bit 6 acts in modes 10, 01
// (R12) Ready bit 0 read-only; bits 5..1 zero
// (R13) Low-power brownout ORed into brownout request
// (R14) Low-power brownout enabled by bit, erased state
// (R15) Low-power brownout sets same cause flag
// (R16) Pin enabled by programming bit or enable bit
// (R17) Filtered low pin holds reset; short pulses rejected
// (R18) Disabled pin is input, pull-up from software
// (R19) Watchdog timeout resets, updates status bits
// (R20) Programming exit repeats power-on sequence
// (R21) Run waits for delay timer and pin release
// (R22) Pin rising after delay: run 10 cycles later
// (R23) Brownout clears cause flag; software sets it
// (R24) Delay counter counts low-frequency ticks
`timescale 1ns/1ps
`include "rsb_defs.vh"

module rsb_reset_sequencer #(
	parameter PWRUP_TICKS    = `RSB_PWRUP_TICKS,
	parameter FILTER_CYCLES  = `RSB_FILTER_CYCLES,
	parameter PIN_FILTER     = `RSB_PIN_FILTER_CYCLES,
	parameter RELEASE_CYCLES = `RSB_PIN_RELEASE_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        power_on_reset,
	input  wire        program_mode,
	input  wire        supply_below_threshold,
	input  wire        brownout_circuit_ready,
	input  wire        low_power_brownout_trip,
	input  wire        external_reset_pin,
	input  wire        watchdog_timeout,
	input  wire        sleep_mode,
	input  wire        lf_tick,
	input  wire        sw_pullup_enable,
	input  wire [1:0]  brownout_mode_select,
	input  wire        powerup_delay_disable_n,
	input  wire        low_power_brownout,
	input  wire        external_reset_pin_enable,
	input  wire        low_voltage_programming,
	output reg         core_reset,
	output reg         brownout_reset,
	output reg         brownout_enable,
	output reg         bandgap_force_on,
	output reg         wake_hold,
	output reg         pin_pullup_enable,
	output reg         pin_gpio_input
);

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam ST_HOLD    = 3'd0;
	localparam ST_DELAY   = 3'd1;
	localparam ST_PIN     = 3'd2;
	localparam ST_RELEASE = 3'd3;
	localparam ST_RUN     = 3'd4;

	reg [2:0]  state;
	reg [2:0]  next_state;
	reg [31:0] pwr_cnt;
	reg [15:0] flt_cnt;
	reg [7:0]  pin_cnt;
	reg [7:0]  rel_cnt;
	reg        pin_low_filt;
	reg        prog_q;
	reg        sw_enable;
	reg        fast_start;
	reg        brownout_flag_n;
	reg        timeout_n;
	reg        powerdown_n;
	reg [3:0]  aw_addr;
	reg        aw_have;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg        w_have;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	function mon_active;
		input [1:0] mode;
		input       sw_en;
		input       sleeping;
		begin
			case (mode) // R4
				`RSB_MODE_ALWAYS_ON:    mon_active = 1'b1; // R5
				`RSB_MODE_OFF_IN_SLEEP: mon_active = ~sleeping; // R6
				`RSB_MODE_SOFTWARE:     mon_active = sw_en; // R7 R10
				default:                mon_active = 1'b0; // R8
			endcase
		end
	endfunction

	wire mon_on    = mon_active(brownout_mode_select, sw_enable, sleep_mode);
	// Protection only starts once the comparator is ready
	wire bo_arm    = mon_on & brownout_circuit_ready; // R7
	wire bo_dip    = bo_arm & supply_below_threshold;
	// Software mode never delays start-up on readiness or supply
	wire need_wait = (brownout_mode_select == `RSB_MODE_ALWAYS_ON) ||
	                 (brownout_mode_select == `RSB_MODE_OFF_IN_SLEEP); // R5 R6 R7
	wire bo_ok     = ~need_wait | (brownout_circuit_ready & ~supply_below_threshold);
	wire pin_en    = low_voltage_programming | external_reset_pin_enable; // R16
	wire lp_trip   = low_power_brownout & low_power_brownout_trip; // R14
	wire bo_filt   = (flt_cnt >= FILTER_CYCLES[15:0]); // R9
	wire bo_req    = (bo_dip & bo_filt) | lp_trip; // R13
	wire prog_exit = prog_q & ~program_mode; // R20
	wire por_req   = power_on_reset | program_mode | prog_exit;
	wire pin_hold  = pin_en & pin_low_filt; // R17

	// ----------------------------------------
	// Filters
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			flt_cnt      <= 16'h0000;
			pin_cnt      <= 8'h00;
			pin_low_filt <= 1'b0;
			prog_q       <= 1'b0;
		end else begin
			prog_q <= program_mode;
			if (!bo_dip)
				flt_cnt <= 16'h0000;
			else if (!bo_filt)
				flt_cnt <= flt_cnt + 16'h0001; // R9
			// Pin must hold one level for the filter length to change the state
			if (external_reset_pin == ~pin_low_filt)
				pin_cnt <= 8'h00;
			else if (pin_cnt >= PIN_FILTER[7:0] - 8'h01) begin
				pin_cnt      <= 8'h00;
				pin_low_filt <= ~external_reset_pin; // R17
			end else
				pin_cnt <= pin_cnt + 8'h01;
		end
	end

	// ----------------------------------------
	// Start-up sequencer
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_HOLD:    if (!por_req && !bo_req && bo_ok)
					next_state = powerup_delay_disable_n ? ST_PIN : ST_DELAY; // R2 R3
			ST_DELAY:   if (pwr_cnt >= PWRUP_TICKS)
					next_state = ST_PIN; // R1
			ST_PIN:     if (!pin_hold)
					next_state = ST_RELEASE; // R21
			ST_RELEASE: if (rel_cnt >= RELEASE_CYCLES[7:0] - 8'h01)
					next_state = ST_RUN; // R22
			ST_RUN:     if (pin_hold)
					next_state = ST_PIN; // R17
			default:    next_state = ST_HOLD;
		endcase
		if (por_req || bo_req || watchdog_timeout)
			next_state = ST_HOLD; // R19 R20
		if (state == ST_RELEASE && pin_hold)
			next_state = ST_PIN;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state   <= ST_HOLD;
			pwr_cnt <= 32'h0000_0000;
			rel_cnt <= 8'h00;
		end else begin
			state <= next_state;
			// Delay runs independently of the pin
			if (state == ST_DELAY && lf_tick && pwr_cnt < PWRUP_TICKS)
				pwr_cnt <= pwr_cnt + 32'h0000_0001; // R24 R22
			else if (state == ST_HOLD)
				pwr_cnt <= 32'h0000_0000;
			if (state == ST_RELEASE)
				rel_cnt <= rel_cnt + 8'h01;
			else
				rel_cnt <= 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs and status
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_reset        <= 1'b1;
			brownout_reset    <= 1'b0;
			brownout_enable   <= 1'b0;
			bandgap_force_on  <= 1'b0;
			wake_hold         <= 1'b0;
			pin_pullup_enable <= 1'b1;
			pin_gpio_input    <= 1'b0;
			timeout_n         <= 1'b1;
			powerdown_n       <= 1'b1;
		end else begin
			core_reset      <= (next_state != ST_RUN); // R1 R21
			brownout_reset  <= bo_req; // R13
			brownout_enable <= mon_on;
			bandgap_force_on <= fast_start &&
				(brownout_mode_select == `RSB_MODE_OFF_IN_SLEEP ||
				 brownout_mode_select == `RSB_MODE_SOFTWARE); // R11
			// Wake waits for readiness only in off-in-sleep mode, whether or not sleep is active
			wake_hold <= (brownout_mode_select == `RSB_MODE_OFF_IN_SLEEP) &
				~brownout_circuit_ready; // R6 R5
			pin_pullup_enable <= pin_en | sw_pullup_enable; // R18
			pin_gpio_input    <= ~pin_en; // R18
			if (por_req) begin
				timeout_n   <= 1'b1;
				powerdown_n <= 1'b1;
			end else if (watchdog_timeout) begin
				timeout_n   <= 1'b0; // R19
				powerdown_n <= ~sleep_mode;
			end
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready   <= 1'b1;
			s_axi_wready    <= 1'b1;
			s_axi_bvalid    <= 1'b0;
			s_axi_bresp     <= `RSB_RESP_OKAY;
			s_axi_arready   <= 1'b1;
			s_axi_rvalid    <= 1'b0;
			s_axi_rresp     <= `RSB_RESP_OKAY;
			s_axi_rdata     <= 32'h0000_0000;
			aw_have         <= 1'b0;
			aw_addr         <= 4'h0;
			w_have          <= 1'b0;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			sw_enable       <= `RSB_SW_ENABLE_RESET;
			fast_start      <= `RSB_FAST_START_RESET;
			brownout_flag_n <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RSB_RESP_OKAY;
				if (aw_addr == `RSB_ADDR_BROWNOUT_CONTROL) begin
					if (w_strb[0]) begin
						sw_enable  <= w_data[`RSB_BIT_SW_ENABLE]; // R10
						fast_start <= w_data[`RSB_BIT_FAST_START]; // R11
					end
				end else if (aw_addr == `RSB_ADDR_RESET_STATUS) begin
					if (w_strb[0] && w_data[`RSB_BIT_BROWNOUT_FLAG_N])
						brownout_flag_n <= 1'b1; // R23
				end else
					s_axi_bresp <= `RSB_RESP_SLVERR;
			end
			// Hardware clear wins over a software set in the same cycle
			if (bo_req)
				brownout_flag_n <= 1'b0; // R15 R23
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RSB_RESP_OKAY;
				s_axi_rdata   <= 32'h0000_0000;
				if (s_axi_araddr == `RSB_ADDR_BROWNOUT_CONTROL) begin
					s_axi_rdata[`RSB_BIT_SW_ENABLE]  <= sw_enable;
					s_axi_rdata[`RSB_BIT_FAST_START] <= fast_start;
					s_axi_rdata[`RSB_BIT_READY]      <= bo_arm; // R12
				end else if (s_axi_araddr == `RSB_ADDR_RESET_STATUS) begin
					s_axi_rdata[`RSB_BIT_BROWNOUT_FLAG_N] <= brownout_flag_n;
					s_axi_rdata[`RSB_BIT_TIMEOUT_N]       <= timeout_n; // R19
					s_axi_rdata[`RSB_BIT_POWERDOWN_N]     <= powerdown_n;
					s_axi_rdata[`RSB_BIT_RUNNING]         <= (state == ST_RUN);
				end else
					s_axi_rresp <= `RSB_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // rsb_reset_sequencer

// ===== sim/rsb_checker_assertions.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
module rsb_checker (
	input logic       aclk,
	input logic       aresetn,
	input logic       power_on_reset,
	input logic       watchdog_timeout,
	input logic       sleep_mode,
	input logic       brownout_circuit_ready,
	input logic       low_power_brownout_trip,
	input logic       low_power_brownout,
	input logic       external_reset_pin,
	input logic       external_reset_pin_enable,
	input logic       low_voltage_programming,
	input logic [1:0] brownout_mode_select,
	input logic       core_reset,
	input logic       brownout_reset,
	input logic       brownout_enable,
	input logic       bandgap_force_on,
	input logic       wake_hold,
	input logic       pin_gpio_input
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Config must settle for two samples since outputs are registered
	sequence s_gpio_cfg;
		(!external_reset_pin_enable && !low_voltage_programming) [*2];
	endsequence
	sequence s_pin_on;
		low_voltage_programming [*2];
	endsequence
	property p_por_hold; power_on_reset [*3] |-> core_reset; endproperty
	a_por_hold: assert property (p_por_hold) else $error("run during power-on");
	property p_lp_or; (low_power_brownout && low_power_brownout_trip) [*5] |-> brownout_reset;
	endproperty
	a_lp_or: assert property (p_lp_or) else $error("low-power trip not combined");
	property p_bo_hold; brownout_reset [*2] |-> core_reset; endproperty
	a_bo_hold: assert property (p_bo_hold) else $error("run during brownout");
	property p_pin_release; $fell(core_reset) && (external_reset_pin_enable ||
		low_voltage_programming) |-> $past(external_reset_pin, 10); endproperty
	a_pin_release: assert property (p_pin_release) else $error("run too soon after pin");
	property p_gpio; s_gpio_cfg |-> pin_gpio_input; endproperty
	a_gpio: assert property (p_gpio) else $error("pin not released to input");
	property p_pin_on; s_pin_on |-> !pin_gpio_input; endproperty
	a_pin_on: assert property (p_pin_on) else $error("pin reset not enabled");
	property p_fast; (brownout_mode_select[1] == brownout_mode_select[0]) [*2]
		|-> !bandgap_force_on; endproperty
	a_fast: assert property (p_fast) else $error("fast start acts in wrong mode");
	property p_mode_on; (brownout_mode_select == 2'b11) [*2] |-> brownout_enable && !wake_hold;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("always-on mode wrong");
	property p_mode_off; (brownout_mode_select == 2'b00) [*2] |-> !brownout_enable; endproperty
	a_mode_off: assert property (p_mode_off) else $error("off mode enables monitor");
	property p_sleep_off; (brownout_mode_select == 2'b10 && sleep_mode) [*2] |-> !brownout_enable;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("monitor on in sleep");
	property p_wake; (brownout_mode_select == 2'b10 && !brownout_circuit_ready) [*2] |-> wake_hold;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not held for ready");
	property p_wdt; $rose(watchdog_timeout) |-> ##[1:3] core_reset; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
endmodule // rsb_checker

bind rsb_reset_sequencer rsb_checker u_rsb_checker (.*);

// ===== sim/rsb_far_side.sv
// Model of the supply comparators and the external reset pin driver
`timescale 1ns/1ps
module rsb_far_side (
	input  logic aclk,
	output logic power_on_reset,
	output logic supply_below_threshold,
	output logic brownout_circuit_ready,
	output logic low_power_brownout_trip,
	output logic external_reset_pin
);
	// Starts in power-on with the pin driven low until released
	initial begin
		power_on_reset = 1'b1;
		supply_below_threshold = 1'b0;
		brownout_circuit_ready = 1'b1;
		low_power_brownout_trip = 1'b0;
		external_reset_pin = 1'b0;
	end
	// Levels move just after an edge; the pin is held for as long as the caller waits
	task automatic set(input int sel, input logic v);
		@(posedge aclk);
		case (sel)
			0: power_on_reset <= v;
			1: supply_below_threshold <= v;
			2: brownout_circuit_ready <= v;
			3: low_power_brownout_trip <= v;
			default: external_reset_pin <= v;
		endcase
	endtask
endmodule // rsb_far_side

// ===== sim/tb_reset_sequencer_brownout.sv
// Testbench for the reset sequencer with brown-out control
`timescale 1ns/1ps
`include "rsb_defs.vh"
module tb_reset_sequencer_brownout;
	logic aclk = 1'b0, aresetn = 1'b0, bo;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic program_mode = 0, watchdog_timeout = 0, sleep_mode = 0, lf_tick = 0, sw_pullup_enable = 0;
	logic [1:0] brownout_mode_select = 2'b11;
	logic powerup_delay_disable_n = 0, low_power_brownout = 1;
	logic external_reset_pin_enable = 1, low_voltage_programming = 0;
	logic power_on_reset, supply_below_threshold, brownout_circuit_ready;
	logic low_power_brownout_trip, external_reset_pin;
	logic core_reset, brownout_reset, brownout_enable, bandgap_force_on, wake_hold;
	logic pin_pullup_enable, pin_gpio_input;
	int n_fail = 0, comparisons = 0, last;

	always #25 aclk = ~aclk;
	// Short delay counts keep the run brief
	rsb_reset_sequencer #(.PWRUP_TICKS(4), .FILTER_CYCLES(3)) u_rsb_reset_sequencer (.*);
	rsb_far_side u_rsb_far_side (.*);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdreg(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic ticks;
		repeat (4) begin
			@(posedge aclk);
			lf_tick <= 1'b1;
			@(posedge aclk);
			lf_tick <= 1'b0;
		end
	endtask
	task automatic run_within(input int n);
		last = 0;
		while (core_reset !== 1'b0 && last < n) begin
			@(posedge aclk);
			last++;
		end
	endtask
	task automatic watch(input int n);
		bo = 1'b0;
		repeat (n) begin
			@(posedge aclk);
			bo = bo | brownout_reset;
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		cyc(16);
		aresetn <= 1'b1;
		rdreg(4'h0);
		chk(rd, 32'h0000_0081);
		rdreg(4'h8);
		chk(32'(rs), 32'(`RSB_RESP_SLVERR));
		wr(4'h8, 32'h0000_0000);
		chk(32'(rs), 32'(`RSB_RESP_SLVERR));
		wr(4'h0, 32'h0000_0080);
		chk(32'(rs), 32'(`RSB_RESP_OKAY));
		u_rsb_far_side.set(0, 1'b0);
		cyc(40);
		chk(32'(core_reset), 32'h1);
		ticks();
		cyc(20);
		chk(32'(core_reset), 32'h1);
		u_rsb_far_side.set(4, 1'b1);
		run_within(40);
		chk(32'(last >= `RSB_PIN_RELEASE_CYCLES && last <= 17), 32'h1);
		rdreg(4'h4);
		chk(rd & 32'h0000_0009, 32'h0000_0008);
		wr(4'h4, 32'h0000_0001);
		u_rsb_far_side.set(1, 1'b1);
		cyc(1);
		u_rsb_far_side.set(1, 1'b0);
		watch(8);
		chk(32'(bo), 32'h0);
		u_rsb_far_side.set(1, 1'b1);
		watch(8);
		u_rsb_far_side.set(1, 1'b0);
		chk(32'(bo), 32'h1);
		rdreg(4'h4);
		chk(rd & 32'h0000_0001, 32'h0);
		cyc(20);
		chk(32'(core_reset), 32'h1);
		ticks();
		run_within(40);
		chk(32'(core_reset), 32'h0);
		wr(4'h4, 32'h0000_0001);
		u_rsb_far_side.set(3, 1'b1);
		watch(8);
		u_rsb_far_side.set(3, 1'b0);
		chk(32'(bo), 32'h1);
		rdreg(4'h4);
		chk(rd & 32'h0000_0001, 32'h0);
		ticks();
		run_within(40);
		watchdog_timeout <= 1'b1;
		cyc(1);
		watchdog_timeout <= 1'b0;
		rdreg(4'h4);
		chk(rd & 32'h0000_0002, 32'h0);
		ticks();
		run_within(40);
		program_mode <= 1'b1;
		cyc(3);
		program_mode <= 1'b0;
		cyc(30);
		chk(32'(core_reset), 32'h1);
		ticks();
		run_within(40);
		chk(32'(core_reset), 32'h0);
		powerup_delay_disable_n <= 1'b1;
		u_rsb_far_side.set(0, 1'b1);
		cyc(3);
		u_rsb_far_side.set(0, 1'b0);
		run_within(40);
		chk(32'(core_reset), 32'h0);
		powerup_delay_disable_n <= 1'b0;
		wr(4'h0, 32'h0000_00c0);
		for (int m = 0; m < 4; m++) begin
			brownout_mode_select <= 2'(m);
			cyc(3);
			chk({30'h0, brownout_enable, bandgap_force_on}, {30'h0, m != 0, m == 1 || m == 2});
			rdreg(4'h0);
			chk(rd, {24'h0, 7'h60, m != 0});
		end
		brownout_mode_select <= 2'b01;
		wr(4'h0, 32'h0000_0040);
		u_rsb_far_side.set(1, 1'b1);
		watch(8);
		u_rsb_far_side.set(1, 1'b0);
		chk({31'h0, bo | brownout_enable}, 32'h0);
		brownout_mode_select <= 2'b10;
		sleep_mode <= 1'b1;
		u_rsb_far_side.set(2, 1'b0);
		cyc(3);
		chk({30'h0, brownout_enable, wake_hold}, 32'h1);
		sleep_mode <= 1'b0;
		brownout_mode_select <= 2'b11;
		cyc(3);
		chk(32'(wake_hold), 32'h0);
		u_rsb_far_side.set(2, 1'b1);
		for (int k = 0; k < 4; k++) begin
			{external_reset_pin_enable, low_voltage_programming} <= 2'(k);
			cyc(3);
			chk({30'h0, pin_gpio_input, pin_pullup_enable}, {30'h0, k == 0, k != 0});
		end
		final_report();
	end

	// Generous bound of 20000 cycles: the tests need a few hundred cycles
	initial begin
		#1_000_000;
		n_fail++;
		final_report();
	end
endmodule // tb_reset_sequencer_brownout
